/* File: hw/atd_defs.svh */
`ifndef ATD_DEFS_SVH
`define ATD_DEFS_SVH

// word indices on the read port
`define ATD_IDX_POSITION 3'h0
`define ATD_IDX_OFFSET 3'h1
`define ATD_IDX_AMBIENT 3'h2
`define ATD_IDX_FEED 3'h3
`define ATD_IDX_RESERVED 3'h4
`define ATD_IDX_FLAGS 3'h5
`define ATD_WORD_COUNT 6

`define ATD_WORD_RST 16'h0000
`define ATD_ZERO_WORD 16'h0000
`define ATD_ZERO_BYTE 8'h00

// limits of the decoded values, temperatures held x10
`define ATD_POS_MAX 16'h0064
`define ATD_OFS_ABS_MAX 16'h0190
`define ATD_OFS_REL_MAX 16'h0032
`define ATD_OFS_REL_MIN 16'hffce
`define ATD_AMB_MAX 16'h0190
`define ATD_FEED_MAX 16'h0320
// raw temperature steps are half degrees, so x10 is raw times five
`define ATD_HALF_DEG_SCALE 16'h0005

// flag word bit positions, numbered from the lsb
`define ATD_FLG_OBSTRUCT 0
`define ATD_FLG_WEAK 1
`define ATD_FLG_RADIO_ERR 2
`define ATD_FLG_WINDOW 3
`define ATD_FLG_CHARGE 4
`define ATD_FLG_HARVEST 5
`define ATD_FLG_TEMP_SEL 6
`define ATD_FLG_MODE 7
`define ATD_FLG_RSVD_ZERO 8'h00

`define ATD_ERR_CNT_W 3
`define ATD_ERR_LIMIT 3'h6
`define ATD_ERR_CNT_MAX 3'h7
`define ATD_ERR_CNT_ZERO 3'h0
`define ATD_ERR_CNT_ONE 3'h1

`endif

/* File: hw/atd_pkg.sv */
package atd_pkg;

    typedef enum logic {
        ATD_PROF_ACTUATOR,
        ATD_PROF_UNIVERSAL
    } atd_profile_t;

    typedef logic [15:0] atd_word_t;

    typedef struct packed {
        logic [5:0][15:0] words;
        logic [2:0] err_cnt;
        logic [15:0] rd_data;
        logic rd_valid;
        logic updated;
    } atd_state_t;

endpackage : atd_pkg

/* File: hw/atd_if.sv */
`timescale 1ns/10ps

interface atd_if;
    logic [7:0] top_telegram_byte;
    logic [7:0] mid_high_telegram_byte;
    logic [7:0] mid_low_telegram_byte;
    logic [7:0] bottom_telegram_byte;
    logic [15:0] position;
    logic [15:0] offset;
    logic [15:0] temperature;
    logic temp_is_feed;

    modport feed (
        output top_telegram_byte, mid_high_telegram_byte, mid_low_telegram_byte,
        output bottom_telegram_byte,
        input position, offset, temperature, temp_is_feed
    );
    modport conv (
        input top_telegram_byte, mid_high_telegram_byte, mid_low_telegram_byte,
        input bottom_telegram_byte,
        output position, offset, temperature, temp_is_feed
    );
endinterface : atd_if

/* File: hw/atd_unpack.sv */
`timescale 1ns/10ps
`include "atd_defs.svh"

module atd_unpack (
    atd_if.conv tel
);

    function automatic logic [15:0] atd_clamp_u(input logic [15:0] v, input logic [15:0] max);
        atd_clamp_u = (v > max) ? max : v;
    endfunction : atd_clamp_u

    function automatic logic [15:0] atd_half_deg(input logic [7:0] raw);
        atd_half_deg = {`ATD_ZERO_BYTE, raw} * `ATD_HALF_DEG_SCALE;
    endfunction : atd_half_deg

    logic [15:0] rel_raw;
    logic [15:0] rel_scaled;
    logic [15:0] abs_scaled;
    logic mode_abs;

    assign mode_abs = tel.bottom_telegram_byte[`ATD_FLG_MODE];
    assign tel.temp_is_feed = tel.bottom_telegram_byte[`ATD_FLG_TEMP_SEL];

    // position byte is already in percent, out-of-range codes saturate
    assign tel.position = atd_clamp_u({`ATD_ZERO_BYTE, tel.top_telegram_byte}, `ATD_POS_MAX); // R1

    // relative offset is a signed byte of half degrees
    assign rel_raw = {{8{tel.mid_high_telegram_byte[7]}}, tel.mid_high_telegram_byte};
    assign rel_scaled = 16'($signed(rel_raw) * $signed(`ATD_HALF_DEG_SCALE));
    assign abs_scaled = atd_half_deg(tel.mid_high_telegram_byte);

    always_comb begin
        if (mode_abs) begin
            tel.offset = atd_clamp_u(abs_scaled, `ATD_OFS_ABS_MAX); // R2
        end else if ($signed(rel_scaled) > $signed(`ATD_OFS_REL_MAX)) begin
            tel.offset = `ATD_OFS_REL_MAX; // R3
        end else if ($signed(rel_scaled) < $signed(`ATD_OFS_REL_MIN)) begin
            tel.offset = `ATD_OFS_REL_MIN; // R3
        end else begin
            tel.offset = rel_scaled; // R3
        end
    end

    // ambient and feed share one raw byte, only the limit differs
    assign tel.temperature = tel.temp_is_feed ?
        atd_clamp_u(atd_half_deg(tel.mid_low_telegram_byte), `ATD_FEED_MAX) : // R5
        atd_clamp_u(atd_half_deg(tel.mid_low_telegram_byte), `ATD_AMB_MAX); // R4

endmodule : atd_unpack

/* File: hw/atd_decoder.sv */
`timescale 1ns/10ps
`include "atd_defs.svh"

// Contract
// (R1) position word is percent, zero to hundred
// (R2) absolute offset: 0..40 degC times ten
// (R3) relative offset: signed -5..+5 degC times ten
// (R4) ambient word: 0..40 degC times ten
// (R5) feed word: 0..80 degC times ten
// (R6) sixteen-bit flag word, upper byte reserved
// (R7) bit7 offset mode, 0 relative 1 absolute
// (R8) bit6 picks updated temperature, other unchanged
// (R9) bit5 harvesting, bit1 weak, bit0 obstructed
// (R10) bit4 charge sufficient, bit3 window open
// (R11) bit2 set after six consecutive errors
// (R12) flag bits numbered upward from lsb
// (R13) universal profile copies bytes, top first
// (R14) reserved word and bits read zero
module atd_decoder (
    input wire logic clk,
    input wire logic reset,
    input wire logic tel_valid,
    input wire atd_pkg::atd_profile_t tel_profile,
    input wire logic [7:0] top_telegram_byte,
    input wire logic [7:0] mid_high_telegram_byte,
    input wire logic [7:0] mid_low_telegram_byte,
    input wire logic [7:0] bottom_telegram_byte,
    input wire logic rd_en,
    input wire logic [2:0] rd_index,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic updated
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the actuator payload

    atd_if tel_bus ();

    assign tel_bus.top_telegram_byte = top_telegram_byte;
    assign tel_bus.mid_high_telegram_byte = mid_high_telegram_byte;
    assign tel_bus.mid_low_telegram_byte = mid_low_telegram_byte;
    assign tel_bus.bottom_telegram_byte = bottom_telegram_byte;

    atd_unpack u_unpack (
        .tel(tel_bus.conv)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // state

    atd_pkg::atd_state_t st;
    atd_pkg::atd_state_t next_st;

    // unmapped indices and the reserved word answer zero
    function automatic logic [15:0] atd_read_word(input logic [5:0][15:0] w,
                                                  input logic [2:0] idx);
        case (idx)
            `ATD_IDX_POSITION: atd_read_word = w[`ATD_IDX_POSITION];
            `ATD_IDX_OFFSET: atd_read_word = w[`ATD_IDX_OFFSET];
            `ATD_IDX_AMBIENT: atd_read_word = w[`ATD_IDX_AMBIENT];
            `ATD_IDX_FEED: atd_read_word = w[`ATD_IDX_FEED];
            `ATD_IDX_FLAGS: atd_read_word = w[`ATD_IDX_FLAGS];
            default: atd_read_word = `ATD_ZERO_WORD; // R14
        endcase
    endfunction : atd_read_word

    logic is_act;
    logic is_univ;
    logic err_now;
    logic [2:0] err_next;

    assign is_act = tel_valid && (tel_profile == atd_pkg::ATD_PROF_ACTUATOR);
    assign is_univ = tel_valid && (tel_profile == atd_pkg::ATD_PROF_UNIVERSAL);
    // bit2 of the raw status byte is one error report per telegram
    assign err_now = bottom_telegram_byte[`ATD_FLG_RADIO_ERR];

    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.updated = 1'b0;
        err_next = st.err_cnt;
        if (is_act) begin
            // saturating count of consecutive error reports
            if (!err_now) begin
                err_next = `ATD_ERR_CNT_ZERO; // R11
            end else if (st.err_cnt != `ATD_ERR_CNT_MAX) begin
                err_next = st.err_cnt + `ATD_ERR_CNT_ONE; // R11
            end
            next_st.err_cnt = err_next;
            next_st.words[`ATD_IDX_POSITION] = tel_bus.position; // R1
            next_st.words[`ATD_IDX_OFFSET] = tel_bus.offset; // R2 R3
            if (tel_bus.temp_is_feed) begin
                next_st.words[`ATD_IDX_FEED] = tel_bus.temperature; // R5 R8
            end else begin
                next_st.words[`ATD_IDX_AMBIENT] = tel_bus.temperature; // R4 R8
            end
            next_st.words[`ATD_IDX_FLAGS] = {`ATD_FLG_RSVD_ZERO, // R6
                bottom_telegram_byte[`ATD_FLG_MODE], // R7 R12
                bottom_telegram_byte[`ATD_FLG_TEMP_SEL], // R8
                bottom_telegram_byte[`ATD_FLG_HARVEST], // R9
                bottom_telegram_byte[`ATD_FLG_CHARGE], // R10
                bottom_telegram_byte[`ATD_FLG_WINDOW], // R10
                (err_next >= `ATD_ERR_LIMIT), // R11
                bottom_telegram_byte[`ATD_FLG_WEAK], // R9
                bottom_telegram_byte[`ATD_FLG_OBSTRUCT]}; // R9
            next_st.updated = 1'b1;
        end else if (is_univ) begin
            // flag word and error count are left as they were
            next_st.words[`ATD_IDX_POSITION] = {`ATD_ZERO_BYTE, top_telegram_byte}; // R13
            next_st.words[`ATD_IDX_OFFSET] = {`ATD_ZERO_BYTE, mid_high_telegram_byte}; // R13
            next_st.words[`ATD_IDX_AMBIENT] = {`ATD_ZERO_BYTE, mid_low_telegram_byte}; // R13
            next_st.words[`ATD_IDX_FEED] = {`ATD_ZERO_BYTE, bottom_telegram_byte}; // R13
            next_st.updated = 1'b1;
        end
        next_st.words[`ATD_IDX_RESERVED] = `ATD_ZERO_WORD; // R14
        // a read in the update cycle sees the words from before the telegram
        if (rd_en) begin
            next_st.rd_data = atd_read_word(st.words, rd_index); // R14
            next_st.rd_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign rd_valid = st.rd_valid;
    assign updated = st.updated;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    chk_pos_range: assert property (@(posedge clk) disable iff (reset) // R1
        is_act |=> (st.words[`ATD_IDX_POSITION] <= `ATD_POS_MAX) && updated)
        else $error("position word above hundred percent");

    chk_offset_abs: assert property (@(posedge clk) disable iff (reset) // R2
        (is_act && bottom_telegram_byte[`ATD_FLG_MODE])
        |=> st.words[`ATD_IDX_OFFSET] <= `ATD_OFS_ABS_MAX)
        else $error("absolute offset out of range");

    chk_offset_rel: assert property (@(posedge clk) disable iff (reset) // R3
        (is_act && !bottom_telegram_byte[`ATD_FLG_MODE])
        |=> ($signed(st.words[`ATD_IDX_OFFSET]) <= $signed(`ATD_OFS_REL_MAX))
        && ($signed(st.words[`ATD_IDX_OFFSET]) >= $signed(`ATD_OFS_REL_MIN)))
        else $error("relative offset out of range");

    chk_ambient_range: assert property (@(posedge clk) disable iff (reset) // R4
        (is_act && !tel_bus.temp_is_feed)
        |=> st.words[`ATD_IDX_AMBIENT] <= `ATD_AMB_MAX)
        else $error("ambient temperature out of range");

    chk_feed_range: assert property (@(posedge clk) disable iff (reset) // R5
        (is_act && tel_bus.temp_is_feed)
        |=> st.words[`ATD_IDX_FEED] <= `ATD_FEED_MAX)
        else $error("feed temperature out of range");

    chk_flags_upper: assert property (@(posedge clk) disable iff (reset) // R6
        st.words[`ATD_IDX_FLAGS][15:8] == `ATD_FLG_RSVD_ZERO)
        else $error("reserved flag bits not zero");

    chk_mode_bit: assert property (@(posedge clk) disable iff (reset) // R7
        is_act |=> st.words[`ATD_IDX_FLAGS][`ATD_FLG_MODE]
        == $past(bottom_telegram_byte[`ATD_FLG_MODE]))
        else $error("offset mode bit not taken from telegram");

    chk_temp_keep: assert property (@(posedge clk) disable iff (reset) // R8
        (is_act && !tel_bus.temp_is_feed) |=> $stable(st.words[`ATD_IDX_FEED]))
        else $error("feed word changed by ambient telegram");

    chk_temp_keep_amb: assert property (@(posedge clk) disable iff (reset) // R8
        (is_act && tel_bus.temp_is_feed) |=> $stable(st.words[`ATD_IDX_AMBIENT]))
        else $error("ambient word changed by feed telegram");

    chk_status_bits: assert property (@(posedge clk) disable iff (reset) // R9
        is_act |=> {st.words[`ATD_IDX_FLAGS][`ATD_FLG_HARVEST],
        st.words[`ATD_IDX_FLAGS][`ATD_FLG_WEAK:`ATD_FLG_OBSTRUCT]}
        == {$past(bottom_telegram_byte[`ATD_FLG_HARVEST]),
        $past(bottom_telegram_byte[`ATD_FLG_WEAK:`ATD_FLG_OBSTRUCT])})
        else $error("harvest, signal or obstruction bit wrong");

    chk_charge_window: assert property (@(posedge clk) disable iff (reset) // R10
        is_act |=> st.words[`ATD_IDX_FLAGS][`ATD_FLG_CHARGE:`ATD_FLG_WINDOW]
        == $past(bottom_telegram_byte[`ATD_FLG_CHARGE:`ATD_FLG_WINDOW]))
        else $error("charge or window bit wrong");

    chk_radio_clear: assert property (@(posedge clk) disable iff (reset) // R11
        (is_act && !err_now) |=> !st.words[`ATD_IDX_FLAGS][`ATD_FLG_RADIO_ERR])
        else $error("radio error kept after good telegram");

    chk_radio_set: assert property (@(posedge clk) disable iff (reset) // R11
        (is_act && err_now && (st.err_cnt == (`ATD_ERR_LIMIT - `ATD_ERR_CNT_ONE)))
        |=> st.words[`ATD_IDX_FLAGS][`ATD_FLG_RADIO_ERR])
        else $error("radio error not set at sixth error");

    chk_radio_early: assert property (@(posedge clk) disable iff (reset) // R11
        (is_act && err_now && (st.err_cnt < (`ATD_ERR_LIMIT - `ATD_ERR_CNT_ONE)))
        |=> !st.words[`ATD_IDX_FLAGS][`ATD_FLG_RADIO_ERR])
        else $error("radio error set before sixth error");

    chk_mode_numbering: assert property (@(posedge clk) disable iff (reset) // R12
        (is_act && (bottom_telegram_byte == 8'h80))
        |=> st.words[`ATD_IDX_FLAGS] == 16'h0080)
        else $error("flag value 0x80 not absolute mode only");

    chk_univ_copy: assert property (@(posedge clk) disable iff (reset) // R13
        is_univ |=> (st.words[`ATD_IDX_POSITION] == {8'h00, $past(top_telegram_byte)})
        && (st.words[`ATD_IDX_FEED] == {8'h00, $past(bottom_telegram_byte)}))
        else $error("universal bytes not copied top first");

    chk_univ_flags: assert property (@(posedge clk) disable iff (reset) // R13
        is_univ |=> $stable(st.words[`ATD_IDX_FLAGS]))
        else $error("universal telegram changed flag word");

    chk_rsvd_read: assert property (@(posedge clk) disable iff (reset) // R14
        (rd_en && (rd_index == `ATD_IDX_RESERVED)) |=> rd_valid && (rd_data == 16'h0000))
        else $error("reserved word read not zero");

    chk_read_flags: assert property (@(posedge clk) disable iff (reset) // R6
        (rd_en && (rd_index == `ATD_IDX_FLAGS))
        |=> rd_valid && (rd_data == $past(st.words[`ATD_IDX_FLAGS])))
        else $error("flag word read mismatch");

    chk_update_pulse: assert property (@(posedge clk) disable iff (reset) // R8
        updated == $past(tel_valid))
        else $error("update pulse not one cycle after telegram");

    chk_words_idle: assert property (@(posedge clk) disable iff (reset) // R8
        !tel_valid |=> $stable(st.words))
        else $error("words changed without a telegram");

    chk_pos_copy: assert property (@(posedge clk) disable iff (reset) // R1
        (is_act && ({`ATD_ZERO_BYTE, top_telegram_byte} <= `ATD_POS_MAX))
        |=> st.words[`ATD_IDX_POSITION] == {`ATD_ZERO_BYTE, $past(top_telegram_byte)})
        else $error("position byte not copied");

    chk_pos_clamp: assert property (@(posedge clk) disable iff (reset) // R1
        (is_act && ({`ATD_ZERO_BYTE, top_telegram_byte} > `ATD_POS_MAX))
        |=> st.words[`ATD_IDX_POSITION] == `ATD_POS_MAX)
        else $error("position not saturated at hundred");

    chk_offset_abs_scale: assert property (@(posedge clk) disable iff (reset) // R2
        (is_act && bottom_telegram_byte[`ATD_FLG_MODE]
        && (({`ATD_ZERO_BYTE, mid_high_telegram_byte} * `ATD_HALF_DEG_SCALE)
        <= `ATD_OFS_ABS_MAX))
        |=> st.words[`ATD_IDX_OFFSET]
        == ({`ATD_ZERO_BYTE, $past(mid_high_telegram_byte)} * `ATD_HALF_DEG_SCALE))
        else $error("absolute offset not scaled by ten");

    chk_ambient_scale: assert property (@(posedge clk) disable iff (reset) // R4
        (is_act && !tel_bus.temp_is_feed
        && (({`ATD_ZERO_BYTE, mid_low_telegram_byte} * `ATD_HALF_DEG_SCALE)
        <= `ATD_AMB_MAX))
        |=> st.words[`ATD_IDX_AMBIENT]
        == ({`ATD_ZERO_BYTE, $past(mid_low_telegram_byte)} * `ATD_HALF_DEG_SCALE))
        else $error("ambient temperature not scaled by ten");

    chk_radio_stay: assert property (@(posedge clk) disable iff (reset) // R11
        (is_act && err_now && (st.err_cnt >= `ATD_ERR_LIMIT))
        |=> st.words[`ATD_IDX_FLAGS][`ATD_FLG_RADIO_ERR])
        else $error("radio error dropped during error run");

    chk_err_restart: assert property (@(posedge clk) disable iff (reset) // R11
        (is_act && !err_now) |=> st.err_cnt == `ATD_ERR_CNT_ZERO)
        else $error("error count not restarted by good telegram");

    chk_univ_err: assert property (@(posedge clk) disable iff (reset) // R11
        is_univ |=> $stable(st.err_cnt))
        else $error("universal telegram changed error count");

    chk_univ_middle: assert property (@(posedge clk) disable iff (reset) // R13
        is_univ
        |=> (st.words[`ATD_IDX_OFFSET] == {`ATD_ZERO_BYTE, $past(mid_high_telegram_byte)})
        && (st.words[`ATD_IDX_AMBIENT] == {`ATD_ZERO_BYTE, $past(mid_low_telegram_byte)}))
        else $error("universal middle bytes not copied in order");

    chk_read_pulse: assert property (@(posedge clk) disable iff (reset) // R14
        rd_valid == $past(rd_en))
        else $error("read answer not one cycle after request");

    chk_read_hold: assert property (@(posedge clk) disable iff (reset) // R14
        !$past(rd_en) |-> $stable(rd_data))
        else $error("read data changed without a request");

    chk_read_pos: assert property (@(posedge clk) disable iff (reset) // R1
        (rd_en && (rd_index == `ATD_IDX_POSITION))
        |=> rd_data == $past(st.words[`ATD_IDX_POSITION]))
        else $error("position word read mismatch");

    chk_read_offset: assert property (@(posedge clk) disable iff (reset) // R2
        (rd_en && (rd_index == `ATD_IDX_OFFSET))
        |=> rd_data == $past(st.words[`ATD_IDX_OFFSET]))
        else $error("offset word read mismatch");

    chk_read_ambient: assert property (@(posedge clk) disable iff (reset) // R4
        (rd_en && (rd_index == `ATD_IDX_AMBIENT))
        |=> rd_data == $past(st.words[`ATD_IDX_AMBIENT]))
        else $error("ambient word read mismatch");

    chk_read_feed: assert property (@(posedge clk) disable iff (reset) // R5
        (rd_en && (rd_index == `ATD_IDX_FEED))
        |=> rd_data == $past(st.words[`ATD_IDX_FEED]))
        else $error("feed word read mismatch");

    chk_read_unmapped: assert property (@(posedge clk) disable iff (reset) // R14
        (rd_en && (rd_index > `ATD_IDX_FLAGS))
        |=> rd_valid && (rd_data == `ATD_ZERO_WORD))
        else $error("unmapped index read not zero");

    chk_rsvd_store: assert property (@(posedge clk) disable iff (reset) // R14
        st.words[`ATD_IDX_RESERVED] == `ATD_ZERO_WORD)
        else $error("reserved word holds a value");

endmodule : atd_decoder

/* File: test/atd_read_master.sv */
`timescale 1ns/10ps

module atd_read_master (
    input wire logic clk,
    output logic rd_en,
    output logic [2:0] rd_index,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        rd_en = 1'b0;
        rd_index = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one request per call; index flipped after release so a stale index shows
    task automatic read_word(input logic [2:0] idx, output logic [15:0] data,
                             output logic valid);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_index <= idx;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_index <= ~idx;
        @(negedge clk);
        data = rd_data;
        valid = rd_valid;
    endtask : read_word
endmodule : atd_read_master

/* File: test/actuator_telegram_decoder_tb_top.sv */
`timescale 1ns/10ps

module actuator_telegram_decoder_tb_top;
    typedef struct {
        logic prof;
        logic [31:0] b;
        logic [5:0][15:0] w;
    } atd_row_t;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tel_valid = 1'b0;
    atd_pkg::atd_profile_t tel_profile = atd_pkg::ATD_PROF_ACTUATOR;
    logic [31:0] tel_bytes = 32'h0000_0000;
    logic rd_en;
    logic [2:0] rd_index;
    logic [15:0] rd_data;
    logic rd_valid;
    logic updated;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    // words listed flags first, position last
    atd_row_t rows [5] = '{
        '{1'b0, 32'h3250_28b9, {16'h00b9, 16'h0, 16'h0000, 16'h00c8, 16'h0190, 16'h0032}},
        '{1'b0, 32'hfff6_ff42, {16'h0042, 16'h0, 16'h0320, 16'h00c8, 16'hffce, 16'h0064}},
        '{1'b0, 32'h640c_1001, {16'h0001, 16'h0, 16'h0320, 16'h0050, 16'h0032, 16'h0064}},
        '{1'b0, 32'h00ff_5098, {16'h0098, 16'h0, 16'h0320, 16'h0190, 16'h0190, 16'h0000}},
        '{1'b1, 32'ha55a_3cc3, {16'h0098, 16'h0, 16'h00c3, 16'h003c, 16'h005a, 16'h00a5}}
    };

    always #50 clk = ~clk;

    atd_decoder dut_u (
        .clk(clk),
        .reset(reset),
        .tel_valid(tel_valid),
        .tel_profile(tel_profile),
        .top_telegram_byte(tel_bytes[31:24]),
        .mid_high_telegram_byte(tel_bytes[23:16]),
        .mid_low_telegram_byte(tel_bytes[15:8]),
        .bottom_telegram_byte(tel_bytes[7:0]),
        .rd_en(rd_en),
        .rd_index(rd_index),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .updated(updated)
    );

    atd_read_master model_u (
        .clk(clk),
        .rd_en(rd_en),
        .rd_index(rd_index),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic send(input logic prof, input logic [31:0] b);
        @(posedge clk);
        tel_valid <= 1'b1;
        tel_profile <= atd_pkg::atd_profile_t'(prof);
        tel_bytes <= b;
        @(posedge clk);
        tel_valid <= 1'b0;
        tel_bytes <= ~b;
        @(negedge clk);
        chk({15'h0000, updated}, 16'h0001);
    endtask : send

    task automatic read_chk(input logic [2:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        model_u.read_word(idx, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask : read_chk

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the roughly 144 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            send(rows[r].prof, rows[r].b);
            for (int i = 0; i < 6; i++) begin
                read_chk(3'(i), rows[r].w[i]);
            end
        end
        read_chk(3'h6, 16'h0000);
        read_chk(3'h7, 16'h0000);
        // error count must survive a universal telegram in the middle of the run
        for (int k = 1; k <= 6; k++) begin
            if (k == 6) begin
                send(1'b1, 32'h0102_0304);
            end
            send(1'b0, 32'h0000_0004);
            read_chk(3'h5, (k >= 6) ? 16'h0004 : 16'h0000);
        end
        // count stays saturated, so the error flag holds through further errors
        send(1'b0, 32'h0000_00ff);
        read_chk(3'h5, 16'h00ff);
        send(1'b0, 32'h0000_0004);
        read_chk(3'h5, 16'h0004);
        send(1'b0, 32'h0000_0000);
        read_chk(3'h5, 16'h0000);
        send(1'b0, 32'h0000_0004);
        read_chk(3'h5, 16'h0000);
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            read_chk(3'(i), 16'h0000);
        end
        give_verdict();
    end
endmodule : actuator_telegram_decoder_tb_top
